// [logic/mtdf_formatter.sv]
// memory table store, reference resolution and display character generator
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - numeral word holds four BCD digits, top digit in bits 15..12; second word digits 5-8
// - only the most significant digit (4th or 8th) gets special handling
// - hex mode shows every digit unchanged, F included
// - unsigned decimal shows a top digit F as 0
// - signed decimal shows a top digit F as a minus sign
// - a negative value shows one magnitude digit fewer than a positive one
// - nibbles A to F in decimal modes are shown as letters, except a top digit F
// - display width below digit capacity shows asterisks in every position
// - string table is two character codes per word from the first word on
// - string table at most sixteen words, thirty-two characters
// - direct reference keeps the display tracking the table words
// - indirect reference uses the pointer table value as a table number
// - indirect reference is available only with version five connection
// - indirect display follows pointer changes and target contents changes
// - invalid BCD or out-of-range pointer leaves the display unchanged
module mtdf_formatter
  import mtdf_pkg::*;
#(
  parameter int WORDS = TBL_NUM * TBL_WORDS
)(
  // clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_b_i,
  // ahb-lite slave
  input  wire logic                     hsel_i,
  input  wire logic [31:0]              haddr_i,
  input  wire logic [1:0]               htrans_i,
  input  wire logic                     hwrite_i,
  input  wire logic [2:0]               hsize_i,
  input  wire logic [31:0]              hwdata_i,
  input  wire logic                     hready_i,
  output logic      [31:0]              hrdata_o,
  output logic                          hreadyout_o,
  output logic                          hresp_o,
  // controller word writes
  input  wire logic                     ctl_we_i,
  input  wire logic [$clog2(WORDS)-1:0] ctl_addr_i,
  input  wire logic [15:0]              ctl_wdata_i,
  // display character stream
  output logic      [7:0]               disp_char_o,
  output logic      [4:0]               disp_pos_o,
  output logic                          disp_valid_o,
  output logic                          disp_last_o
);
  localparam int AW = $clog2(WORDS);
  localparam int DIG_W = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PTR  = 3'b010,
    ST_EMIT = 3'b100
  } mtdf_state_t;

  logic [15:0]       mem [WORDS];
  logic [31:0]       ctrl;
  logic [TBL_W-1:0]  tbl_sel;
  logic              ptr_err;
  logic [TBL_W-1:0]  target;
  logic [4:0]        pos;
  mtdf_state_t       state;
  logic              dph_wr;
  logic [REG_AW-1:0] dph_addr;
  logic              next_rd_valid;
  logic [5:0]        pass_len;
  logic              pass_end;

  // control fields
  logic              en;
  mtdf_mode_t        mode;
  logic              is_str;
  logic              two;
  logic              ind_eff;
  logic [3:0]        wid;
  logic [4:0]        sw_raw;
  logic [4:0]        sw;

  assign en      = ctrl[CT_EN];
  assign mode    = mtdf_mode_t'(ctrl[CT_MODE_LO +: 2]);
  assign is_str  = ctrl[CT_STR];
  assign two     = ctrl[CT_TWO];
  assign ind_eff = ctrl[CT_IND] & ctrl[CT_V5];
  assign wid     = ctrl[CT_WID_LO +: CT_WID_W];
  assign sw_raw  = ctrl[CT_SW_LO +: CT_SW_W];
  assign sw      = (sw_raw > 5'(TBL_WORDS)) ? 5'(TBL_WORDS) : sw_raw;

  // ahb-lite: zero wait, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  logic addr_ok;
  assign addr_ok = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ) && (hsize_i == HSIZE_WORD);

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dph_wr   <= 1'b0;
      dph_addr <= '0;
    end
    else
    begin
      dph_wr   <= addr_ok && hwrite_i;
      dph_addr <= haddr_i[REG_AW-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl    <= CTRL_RST;
      tbl_sel <= '0;
    end
    else if (dph_wr)
    begin
      if (dph_addr == OFS_CTRL)
        ctrl <= hwdata_i & CTRL_MASK;
      if (dph_addr == OFS_TABLE)
        tbl_sel <= hwdata_i[TBL_W-1:0];
    end
  end

  // read data registered at the address phase
  assign next_rd_valid = addr_ok && !hwrite_i;
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      hrdata_o <= '0;
    else if (next_rd_valid)
    begin
      case (haddr_i[REG_AW-1:0])
        OFS_CTRL:   hrdata_o <= ctrl;
        OFS_TABLE:  hrdata_o <= {{(32-TBL_W){1'b0}}, tbl_sel};
        OFS_STATUS:
        begin
          hrdata_o                         <= '0;
          hrdata_o[ST_BUSY]                <= (state != ST_IDLE);
          hrdata_o[ST_PERR]                <= ptr_err;
          hrdata_o[ST_IND]                 <= ind_eff;
          hrdata_o[ST_TBL_LO +: TBL_W]     <= target;
        end
        default:    hrdata_o <= '0;
      endcase
    end
  end

  // table words written by the controller
  always_ff @(posedge core_clk_i)
  begin
    if (ctl_we_i)
      mem[ctl_addr_i] <= ctl_wdata_i;
  end

  function automatic logic [AW-1:0] waddr(input logic [TBL_W-1:0] t, input logic [3:0] w);
    waddr = AW'(t) * AW'(TBL_WORDS) + AW'(w);
  endfunction

  function automatic logic [7:0] hexchar(input logic [3:0] n);
    hexchar = (n > NIB_NINE) ? CH_A + 8'(n - 4'hA) : CH_ZERO + 8'(n);
  endfunction

  // pointer decode: word 0 of the pointer table as four bcd digits
  logic [15:0]      ptr_word;
  logic [3:0]       ptr_thou;
  logic [3:0]       ptr_hund;
  logic [3:0]       ptr_tens;
  logic [3:0]       ptr_ones;
  logic             ptr_bcd;
  logic             ptr_range;
  logic             ptr_ok;
  logic [9:0]       ptr_val;
  assign ptr_word  = mem[waddr(tbl_sel, 4'h0)];
  assign ptr_thou  = ptr_word[3*DIG_W +: DIG_W];
  assign ptr_hund  = ptr_word[2*DIG_W +: DIG_W];
  assign ptr_tens  = ptr_word[DIG_W +: DIG_W];
  assign ptr_ones  = ptr_word[0 +: DIG_W];
  assign ptr_val   = 10'(ptr_hund) * 10'd100 + 10'(ptr_tens) * 10'd10 + 10'(ptr_ones);
  assign ptr_bcd   = (ptr_thou == 4'h0) && (ptr_hund <= NIB_NINE)
                     && (ptr_tens <= NIB_NINE) && (ptr_ones <= NIB_NINE);
  assign ptr_range = (ptr_val <= 10'(TBL_MAX));
  assign ptr_ok    = ptr_bcd && ptr_range;

  // character count of one pass
  logic [5:0] cap;
  logic [5:0] nchars;
  logic       overflow;
  assign cap      = two ? 6'(DIGS_TWO) : 6'(DIGS_ONE);
  assign overflow = (6'(wid) < cap);
  assign nchars   = is_str ? {sw, 1'b0} : (overflow ? 6'(wid) : cap);

  // pass length frozen while emitting
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pass_len <= '0;
    else if (state != ST_EMIT)
      pass_len <= nchars;
  end
  assign pass_end = (6'(pos) + 6'd1 >= pass_len);

  // character at the current position
  logic [4:0]  lsd_idx;
  logic [15:0] num_word;
  logic [3:0]  nib;
  logic [15:0] str_word;
  logic [7:0]  next_char;
  assign lsd_idx  = 5'(cap) - 5'd1 - pos;
  assign num_word = mem[waddr(target, {3'h0, lsd_idx[2]})];
  assign nib      = num_word[{lsd_idx[1:0], 2'b00} +: 4];
  assign str_word = mem[waddr(target, pos[4:1])];

  always_comb
  begin
    next_char = hexchar(nib);
    if (is_str)
      next_char = pos[0] ? str_word[7:0] : str_word[15:8];
    else if (overflow)
      next_char = CH_STAR;
    else if ((pos == 5'd0) && (nib == NIB_F))
    begin
      case (mode)
        MTDF_UDEC: next_char = CH_ZERO;
        MTDF_SDEC: next_char = CH_MINUS;
        default:   next_char = hexchar(nib);
      endcase
    end
  end

  // refresh sequencer: repeats passes while enabled so the display tracks memory
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state   <= ST_IDLE;
      pos     <= '0;
      target  <= '0;
      ptr_err <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          pos <= '0;
          if (en && ind_eff)
            state <= ST_PTR;
          else if (en)
          begin
            target <= tbl_sel;
            if (nchars != 6'd0)
              state <= ST_EMIT;
          end
        end
        ST_PTR:
        begin
          ptr_err <= !ptr_ok;
          if (ptr_ok)
          begin
            target <= ptr_val[TBL_W-1:0];
            state  <= (nchars != 6'd0) ? ST_EMIT : ST_IDLE;
          end
          else
            state <= ST_IDLE;
        end
        ST_EMIT:
        begin
          pos <= pos + 5'd1;
          if (pass_end)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // display outputs
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      disp_char_o  <= '0;
      disp_pos_o   <= '0;
      disp_valid_o <= 1'b0;
      disp_last_o  <= 1'b0;
    end
    else
    begin
      disp_valid_o <= (state == ST_EMIT);
      disp_last_o  <= (state == ST_EMIT) && pass_end;
      if (state == ST_EMIT)
      begin
        disp_char_o <= next_char;
        disp_pos_o  <= pos;
      end
    end
  end
endmodule

// [logic/mtdf_pkg.sv]
// shared constants for the memory table display formatter
package mtdf_pkg;
  // ahb-lite transfer codes
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_TABLE     = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam int          REG_AW        = 8;
  // control register fields
  localparam int          CT_EN         = 0;
  localparam int          CT_MODE_LO    = 1;
  localparam int          CT_STR        = 3;
  localparam int          CT_TWO        = 4;
  localparam int          CT_IND        = 5;
  localparam int          CT_V5         = 6;
  localparam int          CT_WID_LO     = 8;
  localparam int          CT_WID_W      = 4;
  localparam int          CT_SW_LO      = 16;
  localparam int          CT_SW_W       = 5;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK     = 32'h001F_0F7F;
  // status register fields
  localparam int          ST_BUSY       = 0;
  localparam int          ST_PERR       = 1;
  localparam int          ST_IND        = 2;
  localparam int          ST_TBL_LO     = 8;
  // display modes
  typedef enum logic [1:0] {
    MTDF_HEX  = 2'h0,
    MTDF_UDEC = 2'h1,
    MTDF_SDEC = 2'h2
  } mtdf_mode_t;
  // table geometry
  localparam int          TBL_NUM       = 128;
  localparam int          TBL_WORDS     = 16;
  localparam int          TBL_W         = 7;
  localparam int          DIGS_ONE      = 4;
  localparam int          DIGS_TWO      = 8;
  localparam logic [6:0]  TBL_MAX       = 7'h7F;
  // character codes
  localparam logic [7:0]  CH_ZERO       = 8'h30;
  localparam logic [7:0]  CH_A          = 8'h41;
  localparam logic [7:0]  CH_MINUS      = 8'h2D;
  localparam logic [7:0]  CH_STAR       = 8'h2A;
  localparam logic [3:0]  NIB_F         = 4'hF;
  localparam logic [3:0]  NIB_NINE      = 4'h9;
endpackage

// [test/mtdf_chk.sv]
// assertion checker for the formatter bus and display ports
`timescale 1ns/1ps
module mtdf_chk
  import mtdf_pkg::*;
(
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  // bus
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // display
  input wire logic [7:0]  disp_char_o,
  input wire logic [4:0]  disp_pos_o,
  input wire logic        disp_valid_o,
  input wire logic        disp_last_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_ready_high: assert property (hreadyout_o) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp_o) else $error("error response");
  a_rdata_hold: assert property (!(hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && !hwrite_i
    && hsize_i == HSIZE_WORD) |=> $stable(hrdata_o)) else $error("read data moved");
  a_last_valid: assert property (disp_last_o |-> disp_valid_o) else $error("last without valid");
  a_first_pos: assert property ($rose(disp_valid_o) |-> disp_pos_o == 5'h0) else $error("pass not at 0");
  a_pos_step: assert property (disp_valid_o && !disp_last_o |=> disp_valid_o
    && disp_pos_o == $past(disp_pos_o) + 5'h1) else $error("position skipped");
  a_idle_gap: assert property (disp_last_o |=> !disp_valid_o) else $error("no gap after pass");
  a_pass_bound: assert property ($rose(disp_valid_o) |-> ##[0:31] disp_last_o) else $error("pass too long");
  c_pass: cover property (disp_last_o);
  c_minus: cover property ($rose(disp_valid_o) && disp_char_o == CH_MINUS);
  c_read: cover property (hsel_i && htrans_i == HTRANS_NONSEQ && !hwrite_i);
endmodule
bind mtdf_formatter mtdf_chk u_chk (.core_clk_i, .rst_b_i, .hsel_i, .htrans_i, .hwrite_i, .hsize_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .disp_char_o, .disp_pos_o, .disp_valid_o, .disp_last_o);

// [test/mtdf_ctl_model.sv]
// controller model writing allocated table words
`timescale 1ns/1ps
module mtdf_ctl_model (
  // clock
  input  wire logic        core_clk_i,
  // word writes
  output logic             ctl_we_o,
  output logic [10:0]      ctl_addr_o,
  output logic [15:0]      ctl_wdata_o
);
  initial
  begin
    ctl_we_o    = 1'b0;
    ctl_addr_o  = 11'h0;
    ctl_wdata_o = 16'h0;
  end
  task automatic put(input logic [10:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    ctl_we_o    <= 1'b1;
    ctl_addr_o  <= a;
    ctl_wdata_o <= d;
    @(posedge core_clk_i);
    ctl_we_o    <= 1'b0;
    ctl_wdata_o <= ~d; // no stale word left on the data lines
  endtask
  task automatic put_str(input logic [6:0] tb, input logic [31:0] s, input int n, input int nw);
    logic [7:0] c [2];
    for (int w = 0; w < nw; w++)
    begin
      for (int k = 0; k < 2; k++)
        c[k] = (2 * w + k < n) ? s[8 * (n - 1 - 2 * w - k) +: 8] : 8'h20;
      put({tb, w[3:0]}, {c[0], c[1]});
    end
  endtask
endmodule

// [test/memory_table_display_formatter_bench.sv]
// self-checking bench for the memory table display formatter
`timescale 1ns/1ps
module memory_table_display_formatter_bench;
  import mtdf_pkg::*;
  logic        core_clk_i;
  logic        rst_b_i;
  logic        hsel_i;
  logic [31:0] haddr_i;
  logic [1:0]  htrans_i;
  logic        hwrite_i;
  logic [2:0]  hsize_i;
  logic [31:0] hwdata_i;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        ctl_we_i;
  logic [10:0] ctl_addr_i;
  logic [15:0] ctl_wdata_i;
  logic [7:0]  disp_char_o;
  logic [4:0]  disp_pos_o;
  logic        disp_valid_o;
  logic        disp_last_o;
  logic [63:0] got;
  logic [31:0] rd;
  int          nch;
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;
  mtdf_formatter u_dut (.core_clk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .ctl_we_i, .ctl_addr_i, .ctl_wdata_i,
    .disp_char_o, .disp_pos_o, .disp_valid_o, .disp_last_o);
  mtdf_ctl_model u_ctl (.core_clk_i, .ctl_we_o(ctl_we_i), .ctl_addr_o(ctl_addr_i), .ctl_wdata_o(ctl_wdata_i));
  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    htrans_i <= HTRANS_NONSEQ;
    haddr_i  <= {24'h0, a};
    hwrite_i <= wr;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] m, input logic s, t, i, v, input logic [3:0] w,
    input logic [4:0] sw);
    return {11'h0, sw, 4'h0, w, 1'b0, v, i, t, s, m, 1'b1};
  endfunction
  // skips the pass in flight, then collects one whole pass
  task automatic get_pass();
    do @(negedge core_clk_i); while (disp_last_o !== 1'b1);
    got = 64'h0;
    nch = 0;
    do
    begin
      @(negedge core_clk_i);
      if (disp_valid_o === 1'b1)
      begin
        got = {got[55:0], disp_char_o};
        nch = nch + 1;
      end
    end
    while (disp_last_o !== 1'b1);
  endtask
  task automatic show(input logic [31:0] c, input logic [6:0] tb);
    bus(1'b1, OFS_TABLE, {25'h0, tb});
    bus(1'b1, OFS_CTRL, c);
    get_pass();
  endtask
  task automatic t_regs();
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", rd, CTRL_RST);
    bus(1'b1, OFS_CTRL, 32'hFFFF_FFFE);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl mask", rd, 32'hFFFF_FFFE & CTRL_MASK);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask
  task automatic t_num();
    show(cfg(MTDF_HEX, 0, 0, 0, 0, 4'h4, 5'h0), 7'h2);
    chk("hex", got, "F1A3");
    show(cfg(MTDF_UDEC, 0, 0, 0, 0, 4'h4, 5'h0), 7'h2);
    chk("udec", got, "01A3");
    show(cfg(MTDF_SDEC, 0, 0, 0, 0, 4'h4, 5'h0), 7'h2);
    chk("sdec", got, "-1A3");
    show(cfg(MTDF_SDEC, 0, 1, 0, 0, 4'h8, 5'h0), 7'h3);
    chk("two words", got, "-1234567");
    show(cfg(MTDF_UDEC, 0, 1, 0, 0, 4'h7, 5'h0), 7'h3);
    chk("narrow", got, "*******");
    show(cfg(2'h3, 0, 0, 0, 0, 4'h4, 5'h0), 7'h2);
    chk("mode three", got, "F1A3");
  endtask
  task automatic t_str();
    u_ctl.put_str(7'h7, "ABC", 3, 2);
    show(cfg(MTDF_HEX, 1, 0, 0, 0, 4'h0, 5'h2), 7'h7);
    chk("string", got, "ABC ");
    show(cfg(MTDF_HEX, 1, 0, 0, 0, 4'h0, 5'h11), 7'h7);
    chk("string cap", 64'(nch), 64'h20);
    show(cfg(MTDF_HEX, 0, 0, 0, 0, 4'h4, 5'h0), 7'h2);
    u_ctl.put(11'h020, 16'h0987);
    get_pass();
    chk("tracking", got, "0987");
  endtask
  task automatic t_ind();
    logic [15:0] bad [2];
    bad = '{16'h00A1, 16'h0128};
    show(cfg(MTDF_HEX, 0, 0, 1, 1, 4'h4, 5'h0), 7'h5);
    chk("indirect", got, "4567");
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("shown table", 64'(rd[ST_TBL_LO +: TBL_W]), 64'h3);
    chk("indirect flag", 64'(rd[ST_IND]), 64'h1);
    u_ctl.put(11'h050, 16'h0002);
    get_pass();
    chk("new pointer", got, "0987");
    u_ctl.put(11'h020, 16'h1111);
    get_pass();
    chk("new target", got, "1111");
    show(cfg(MTDF_HEX, 0, 0, 1, 0, 4'h4, 5'h0), 7'h5);
    chk("no version five", got, "0002");
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("direct flag", 64'(rd[ST_IND]), 64'h0);
    show(cfg(MTDF_HEX, 0, 0, 1, 1, 4'h4, 5'h0), 7'h5);
    foreach (bad[b])
    begin
      u_ctl.put(11'h050, bad[b]);
      repeat (20) @(negedge core_clk_i);
      nch = 0;
      repeat (60) @(negedge core_clk_i) nch = nch + int'(disp_valid_o === 1'b1);
      chk("bad pointer chars", 64'(nch), 64'h0);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("bad pointer flag", 64'(rd[ST_PERR]), 64'h1);
    end
  endtask
  initial
  begin
    rst_b_i  = 1'b0;
    hsel_i   = 1'b1;
    haddr_i  = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i  = HSIZE_WORD;
    hwdata_i = 32'h0;
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    u_ctl.put(11'h020, 16'hF1A3);
    u_ctl.put(11'h030, 16'h4567);
    u_ctl.put(11'h031, 16'hF123);
    u_ctl.put(11'h050, 16'h0003);
    t_num();
    t_str();
    t_ind();
    tally_and_finish();
  end
endmodule
